/* File: shared/slf_pkg.sv */
package slf_pkg;
  localparam logic [7:0]  START_BYTE  = 8'h02;
  localparam logic [7:0]  END_BYTE    = 8'h03;
  localparam logic [7:0]  ESC_BYTE    = 8'h1B;
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_PRESET  = 32'hFFFFFFFF;
  localparam int          CRC_BYTES   = 4;
  localparam int          RX_HOLD     = 4;
  localparam logic [2:0]  HOLD_LAST   = 3'h4;
endpackage

/* File: shared/slf_crc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface slf_crc_if;
  logic       clear;
  logic       step;
  logic [7:0] data;
  logic [31:0] crc;
  modport owner (output clear, output step, output data, input crc);
  modport unit (input clear, input step, input data, output crc);
endinterface
`default_nettype wire

/* File: design/slf_crc.sv */
`timescale 1ns/1ps
`default_nettype none
module slf_crc (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // byte stream
  slf_crc_if.unit     crc_if
);
  logic [31:0] stage [0:8];
  logic [31:0] crc_q;

  assign stage[0] = crc_q;
  // msb-first byte update, one bit per stage
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic fb;
      assign fb = stage[b][31] ^ crc_if.data[7-b];
      assign stage[b+1] = {stage[b][30:0], 1'b0} ^ (fb ? slf_pkg::CRC_POLY : 32'h00000000); // R12
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i || crc_if.clear) begin
      crc_q <= slf_pkg::CRC_PRESET; // R12
    end else if (crc_if.step) begin
      crc_q <= stage[8];
    end
  end

  assign crc_if.crc = crc_q;
endmodule
`default_nettype wire

/* File: design/slf_framer.sv */
// Behaviour
// (R01) frame: start byte, message, four check bytes msb first, end byte
// (R02) opening delimiter is 0x02 and begins a message
// (R03) closing delimiter is 0x03 and ends a message
// (R04) no delimiter value in a frame body unless escape precedes it
// (R05) check word is MPEG CRC-32 over raw message bytes only
// (R06) escape byte is 0x1B
// (R07) each 0x02, 0x03, 0x1B in message or check becomes escape plus value
// (R08) compute check first, then escape, then add delimiters
// (R09) receiver drops escape, keeps next byte as data, never as delimiter
// (R10) receiver checks CRC on restored, unescaped bytes
// (R11) unescaped start begins new frame; unescaped end closes it
// (R12) poly 0x04C11DB7, preset ones, msb first, no final inversion
// (R13) bad check or cut-short frame is dropped and error flag pulses; here its message bytes are already out on RX_DATA_O, only the flags mark it
`timescale 1ns/1ps
`default_nettype none
module slf_framer (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       SYS_RST_I,
  // transmit message in
  input  wire logic       TX_VALID_I,
  input  wire logic [7:0] TX_DATA_I,
  input  wire logic       TX_LAST_I,
  output logic            TX_READY_O,
  // serial line out
  output logic            LINE_VALID_O,
  output logic [7:0]      LINE_DATA_O,
  input  wire logic       LINE_READY_I,
  // serial line in
  input  wire logic       LINE_VALID_I,
  input  wire logic [7:0] LINE_DATA_I,
  // received message out
  output logic            RX_VALID_O,
  output logic [7:0]      RX_DATA_O,
  output logic            RX_LAST_O,
  output logic            RX_GOOD_O,
  output logic            RX_ERROR_O
);
  // ---------------- transmitter ----------------
  typedef enum {TX_IDLE, TX_START, TX_MSG, TX_CRC, TX_END} slf_tx_state_t;
  slf_tx_state_t tx_state;
  slf_tx_state_t next_tx_state;
  logic [7:0]    tx_byte;
  logic          tx_esc_pending;
  logic          tx_is_last;
  logic [1:0]    crc_idx;
  logic [31:0]   crc_word;
  logic          tx_byte_valid;
  slf_crc_if     tx_crc ();
  slf_crc_if     rx_crc ();

  slf_crc u_tx_crc (
    .clk_i  (CLK_SYS_I),
    .rst_i  (SYS_RST_I),
    .crc_if (tx_crc)
  );

  // receive check runs over the restored bytes as they leave the hold line
  slf_crc u_rx_crc (
    .clk_i  (CLK_SYS_I),
    .rst_i  (SYS_RST_I),
    .crc_if (rx_crc)
  );

  wire line_free   = !LINE_VALID_O || LINE_READY_I;
  wire tx_take     = TX_READY_O && TX_VALID_I;
  wire [7:0] crc_b = crc_word[31 - 8*crc_idx -: 8];
  wire [7:0] body  = (tx_state == TX_CRC) ? crc_b : tx_byte;
  wire body_rsv    = (body == slf_pkg::START_BYTE) || (body == slf_pkg::END_BYTE) ||
                     (body == slf_pkg::ESC_BYTE); // R07

  assign tx_crc.clear = (tx_state == TX_IDLE);
  assign tx_crc.step  = tx_take;
  assign tx_crc.data  = TX_DATA_I; // R05

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE:  if (TX_VALID_I) next_tx_state = TX_START;
      TX_START: if (line_free) next_tx_state = TX_MSG;
      TX_MSG:   if (line_free && tx_byte_valid && !(body_rsv && !tx_esc_pending) && tx_is_last)
                  next_tx_state = TX_CRC;
      TX_CRC:   if (line_free && !(body_rsv && !tx_esc_pending) && crc_idx == 2'h3)
                  next_tx_state = TX_END;
      TX_END:   if (line_free) next_tx_state = TX_IDLE;
      default:  next_tx_state = TX_IDLE;
    endcase
  end

  wire  body_step = line_free && (tx_state == TX_CRC || tx_byte_valid);
  wire  body_done = body_step && !(body_rsv && !tx_esc_pending);

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      tx_state       <= TX_IDLE;
      tx_esc_pending <= 1'b0;
      tx_byte_valid  <= 1'b0;
      tx_byte        <= 8'h00;
      tx_is_last     <= 1'b0;
      crc_idx        <= 2'h0;
      crc_word       <= 32'h00000000;
      TX_READY_O     <= 1'b0;
      LINE_VALID_O   <= 1'b0;
      LINE_DATA_O    <= 8'h00;
    end else begin
      tx_state <= next_tx_state;
      if (line_free) begin
        LINE_VALID_O <= 1'b0;
      end
      case (tx_state)
        TX_START: if (line_free) begin
          LINE_VALID_O <= 1'b1;
          LINE_DATA_O  <= slf_pkg::START_BYTE; // R02
          crc_idx      <= 2'h0;
        end
        TX_MSG, TX_CRC: if (body_step) begin
          LINE_VALID_O <= 1'b1;
          if (body_rsv && !tx_esc_pending) begin
            LINE_DATA_O    <= slf_pkg::ESC_BYTE; // R06
            tx_esc_pending <= 1'b1; // R04
          end else begin
            LINE_DATA_O    <= body; // R07
            tx_esc_pending <= 1'b0;
            if (tx_state == TX_CRC) crc_idx <= crc_idx + 2'h1; // R01
          end
        end
        TX_END: if (line_free) begin
          LINE_VALID_O <= 1'b1;
          LINE_DATA_O  <= slf_pkg::END_BYTE; // R03
        end
        default: ;
      endcase
      if (tx_state == TX_MSG && body_done) begin
        tx_byte_valid <= 1'b0;
      end
      // capture one raw byte; crc steps on it before any escaping
      if (tx_take) begin
        tx_byte       <= TX_DATA_I;
        tx_is_last    <= TX_LAST_I;
        tx_byte_valid <= 1'b1; // R08
      end
      if (tx_state == TX_MSG && body_done && tx_is_last) begin
        crc_word <= tx_crc.crc; // R08
      end
      TX_READY_O <= (next_tx_state == TX_MSG) && !TX_READY_O && !tx_byte_valid &&
                    !(tx_take) && !(tx_state == TX_MSG && tx_is_last && tx_byte_valid);
    end
  end

  // ---------------- receiver ----------------
  logic        rx_in_frame;
  logic        rx_esc;
  logic [7:0]  hold [0:slf_pkg::RX_HOLD-1];
  logic [2:0]  hold_cnt;

  wire rx_data_byte  = LINE_VALID_I && (rx_esc ||
                       !(LINE_DATA_I == slf_pkg::START_BYTE || LINE_DATA_I == slf_pkg::END_BYTE ||
                         LINE_DATA_I == slf_pkg::ESC_BYTE)); // R09
  wire rx_start      = LINE_VALID_I && !rx_esc && LINE_DATA_I == slf_pkg::START_BYTE; // R11
  wire rx_end        = LINE_VALID_I && !rx_esc && LINE_DATA_I == slf_pkg::END_BYTE; // R11
  wire rx_esc_seen   = LINE_VALID_I && !rx_esc && LINE_DATA_I == slf_pkg::ESC_BYTE;
  wire rx_push       = rx_in_frame && rx_data_byte;
  wire hold_full     = (hold_cnt == slf_pkg::HOLD_LAST);
  wire [31:0] rx_chk = {hold[0], hold[1], hold[2], hold[3]};

  // the newest four restored bytes may be the check word, so bytes leave the
  // hold line only when pushed out; crc runs over the bytes that leave
  assign rx_crc.clear = rx_start;
  assign rx_crc.step  = rx_push && hold_full && !rx_start && !rx_end; // R10
  assign rx_crc.data  = hold[0];

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rx_in_frame <= 1'b0;
      rx_esc      <= 1'b0;
      hold_cnt    <= 3'h0;
      for (int i = 0; i < slf_pkg::RX_HOLD; i++) hold[i] <= 8'h00;
      RX_VALID_O  <= 1'b0;
      RX_DATA_O   <= 8'h00;
      RX_LAST_O   <= 1'b0;
      RX_GOOD_O   <= 1'b0;
      RX_ERROR_O  <= 1'b0;
    end else begin
      RX_VALID_O <= 1'b0;
      RX_LAST_O  <= 1'b0;
      RX_GOOD_O  <= 1'b0;
      RX_ERROR_O <= 1'b0;
      if (LINE_VALID_I) begin
        rx_esc <= rx_esc_seen; // R09
      end
      if (rx_start) begin
        RX_ERROR_O  <= rx_in_frame; // R13
        rx_in_frame <= 1'b1;
        hold_cnt    <= 3'h0;
      end else if (rx_end && rx_in_frame) begin
        rx_in_frame <= 1'b0;
        RX_LAST_O   <= 1'b1;
        RX_GOOD_O   <= hold_full && (rx_chk == rx_crc.crc); // R10
        RX_ERROR_O  <= !(hold_full && (rx_chk == rx_crc.crc)); // R13
      end else if (rx_push) begin
        for (int i = 0; i < slf_pkg::RX_HOLD - 1; i++) hold[i] <= hold[i+1];
        hold[slf_pkg::RX_HOLD-1] <= LINE_DATA_I;
        if (hold_full) begin
          RX_VALID_O <= 1'b1;
          RX_DATA_O  <= hold[0];
        end else begin
          hold_cnt <= hold_cnt + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/slf_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module slf_properties (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       SYS_RST_I,
  // watched ports
  input  wire logic       TX_READY_O,
  input  wire logic       LINE_VALID_O,
  input  wire logic [7:0] LINE_DATA_O,
  input  wire logic       LINE_READY_I,
  input  wire logic       LINE_VALID_I,
  input  wire logic [7:0] LINE_DATA_I,
  input  wire logic       RX_VALID_O,
  input  wire logic       RX_LAST_O,
  input  wire logic       RX_GOOD_O,
  input  wire logic       RX_ERROR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  logic in_esc;
  logic in_frame;
  wire  take   = LINE_VALID_O && LINE_READY_I;
  wire  is_st  = LINE_DATA_O == slf_pkg::START_BYTE;
  wire  is_rsv = is_st || LINE_DATA_O == slf_pkg::END_BYTE || LINE_DATA_O == slf_pkg::ESC_BYTE;
  // tracks escape pairing and framing of accepted line bytes
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      in_esc <= 1'b0;
      in_frame <= 1'b0;
    end else if (take) begin
      in_esc <= !in_esc && LINE_DATA_O == slf_pkg::ESC_BYTE;
      if (!in_esc && is_st) in_frame <= 1'b1;
      else if (!in_esc && LINE_DATA_O == slf_pkg::END_BYTE) in_frame <= 1'b0;
    end
  end
  sequence s_esc_take; take && in_esc; endsequence
  property p_esc_pair; s_esc_take |-> is_rsv; endproperty
  a_esc_pair: assert property (p_esc_pair) else $error("escape not followed by reserved");
  property p_open; take && !in_frame |-> is_st; endproperty
  a_open: assert property (p_open) else $error("frame does not open with start");
  property p_body; take && in_frame && !in_esc |-> !is_st; endproperty
  a_body: assert property (p_body) else $error("bare start inside frame body");
  property p_hold; LINE_VALID_O && !LINE_READY_I |=> LINE_VALID_O && $stable(LINE_DATA_O); endproperty
  a_hold: assert property (p_hold) else $error("line byte dropped before accept");
  property p_rdy; TX_READY_O |=> !TX_READY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_rx_lat; RX_VALID_O |-> $past(LINE_VALID_I); endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("rx byte without line byte");
  property p_last; RX_LAST_O |-> $past(LINE_VALID_I && LINE_DATA_I == slf_pkg::END_BYTE); endproperty
  a_last: assert property (p_last) else $error("frame end without end byte");
  property p_good; RX_GOOD_O |-> RX_LAST_O && !RX_ERROR_O; endproperty
  a_good: assert property (p_good) else $error("good flag outside frame end");
  property p_err; RX_ERROR_O |-> $past(LINE_VALID_I) && !RX_GOOD_O; endproperty
  a_err: assert property (p_err) else $error("error flag without cause");
endmodule
bind slf_framer slf_properties slf_properties_i (.CLK_SYS_I, .SYS_RST_I, .TX_READY_O,
  .LINE_VALID_O, .LINE_DATA_O, .LINE_READY_I, .LINE_VALID_I, .LINE_DATA_I, .RX_VALID_O,
  .RX_LAST_O, .RX_GOOD_O, .RX_ERROR_O);
`default_nettype wire

/* File: tb/slf_line_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module slf_line_peer (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       line_valid_i,
  input  wire logic [7:0] line_data_i,
  input  wire logic [1:0] mode_i,
  output logic            line_ready_o,
  output logic            fwd_valid_o,
  output logic [7:0]      fwd_data_o
);
  int         seed = 36;
  logic [7:0] idx;
  // random stalls on the accepting side
  always @(negedge clk_i) line_ready_o <= !rst_i && ($random(seed) & 3) != 0;
  // loops accepted bytes back; mode 1 flips bit 7 of the first message byte, mode 2 loses end bytes
  always @(posedge clk_i) begin
    if (rst_i) begin
      fwd_valid_o <= 1'b0;
      fwd_data_o <= 8'h00;
      idx <= 8'h00;
    end else begin
      fwd_valid_o <= 1'b0;
      fwd_data_o <= ~fwd_data_o;
      if (line_valid_i && line_ready_o) begin
        idx <= (line_data_i == slf_pkg::START_BYTE) ? 8'h01 : idx + 8'h01;
        fwd_valid_o <= !(mode_i == 2'h2 && line_data_i == slf_pkg::END_BYTE);
        fwd_data_o <= line_data_i ^ {mode_i == 2'h1 && idx == 8'h01, 7'h00};
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       tx_valid = 1'b0;
  logic       tx_last = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [1:0] mode = 2'h0;
  logic       tx_ready, line_valid, line_ready, fwd_valid, rx_valid, rx_last, rx_good, rx_error;
  logic [7:0] line_data, fwd_data, rx_data;
  logic [7:0] exp_line[$];
  logic [7:0] exp_rx[$];
  logic       exp_good = 1'b1;
  int         seed = 36;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         n_good = 0;
  int         n_err = 0;
  slf_framer slf_framer_i (.CLK_SYS_I(clk), .SYS_RST_I(rst), .TX_VALID_I(tx_valid),
    .TX_DATA_I(tx_data), .TX_LAST_I(tx_last), .TX_READY_O(tx_ready), .LINE_VALID_O(line_valid),
    .LINE_DATA_O(line_data), .LINE_READY_I(line_ready), .LINE_VALID_I(fwd_valid),
    .LINE_DATA_I(fwd_data), .RX_VALID_O(rx_valid), .RX_DATA_O(rx_data), .RX_LAST_O(rx_last),
    .RX_GOOD_O(rx_good), .RX_ERROR_O(rx_error));
  slf_line_peer slf_line_peer_i (.clk_i(clk), .rst_i(rst), .line_valid_i(line_valid),
    .line_data_i(line_data), .mode_i(mode), .line_ready_o(line_ready), .fwd_valid_o(fwd_valid),
    .fwd_data_o(fwd_data));
  initial forever #2.5 clk = ~clk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] crc_of(input logic [7:0] m[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (m[i]) begin
      c = c ^ {m[i], 24'h000000};
      for (int k = 0; k < 8; k++) c = c[31] ? (c << 1) ^ slf_pkg::CRC_POLY : c << 1;
    end
    return c;
  endfunction
  function automatic void put(input logic [7:0] b);
    if (b == 8'h02 || b == 8'h03 || b == 8'h1B) exp_line.push_back(8'h1B);
    exp_line.push_back(b);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
    if (line_valid === 1'b1 && line_ready) check("line byte", exp_line.pop_front(), line_data);
    if (rx_valid === 1'b1 && mode == 2'h0) check("rx byte", exp_rx.pop_front(), rx_data);
    if (rx_last === 1'b1) check("rx good", exp_good, rx_good);
    if (rx_good === 1'b1) n_good++;
    if (rx_error === 1'b1) n_err++;
  end
  task automatic send(input int len, input logic [1:0] md);
    logic [7:0]  m[$];
    logic [31:0] c;
    int          t;
    mode = md;
    for (int i = 0; i < len; i++) begin
      t = $random(seed);
      m.push_back(t[3:2] == 2'h0 ? 8'h1B : t[3:2] == 2'h1 ? {7'h01, t[4]} : t[15:8]);
    end
    if (md == 2'h1) m[0] = 8'h55;
    c = crc_of(m);
    exp_line.push_back(slf_pkg::START_BYTE);
    foreach (m[i]) put(m[i]);
    for (int i = 3; i >= 0; i--) put(c[8*i +: 8]);
    exp_line.push_back(slf_pkg::END_BYTE);
    if (md == 2'h0) foreach (m[i]) exp_rx.push_back(m[i]);
    exp_good = (md == 2'h0);
    foreach (m[i]) begin
      tx_valid = 1'b1;
      tx_data = m[i];
      tx_last = (i == len - 1);
      t = 0;
      do @(posedge clk); while (tx_ready !== 1'b1 && ++t < 200);
      @(negedge clk);
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
    t = 0;
    while (exp_line.size() != 0 && t++ < 500) @(negedge clk);
    repeat (10) @(negedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int f = 0; f < 12; f++) send(f == 0 ? 1 : 1 + ($random(seed) & 7), 2'h0);
    send(4, 2'h1);
    send(4, 2'h2);
    send(3, 2'h0);
    check("good count", 13, n_good);
    check("error count", 2, n_err);
    final_report();
  end
endmodule
`default_nettype wire
